// >>> rtl/pm_pkg.sv
// How it works
// - port 3 field 7:6 on pins 0,1,3,4: quasi, push-pull, slow, pull-up
// - port 2 field bits 5:4: quasi, push-pull, slow out, input pull-down
// - bit 3 zero connects card presence pull-up, one disconnects it
// - port 0 field bits 1:0: bus port, reserved, slow output, push-pull
// - full variant reset clears every defined mode bit, bit 2 stays reserved
// - reduced variant has only port 3 field and pull-up bit, reset zero
// - reserved bits read undefined, here zero; never written with ones
// - each led field: off, 2 mA, 4 mA or 10 mA current source
// - led current only drives while its pin is in quasi mode
// - led fields map to port 3 pins 2, 4, 6 and 7 in order
// - reset clears the whole led register, all led drive off
package pm_pkg;
    // ==========================================================
    // bus geometry
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // ==========================================================
    // register indices and byte addresses (index times four)
    localparam logic [7:0]  MODE_IDX      = 8'h91;
    localparam logic [7:0]  LED_IDX       = 8'hF1;
    localparam logic [11:0] MODE_ADDR     = {2'h0, MODE_IDX, 2'h0};
    localparam logic [11:0] LED_ADDR      = {2'h0, LED_IDX, 2'h0};
    // ==========================================================
    // field positions
    localparam int          P3_LSB        = 6;
    localparam int          P2_LSB        = 4;
    localparam int          PULLUP_OFF_BIT = 3;
    localparam int          P0_LSB        = 0;
    // ==========================================================
    // implemented bits and reset values
    localparam logic [7:0]  MODE_MASK_FULL = 8'hFB;
    localparam logic [7:0]  MODE_MASK_RED  = 8'hC8;
    localparam logic [7:0]  LED_MASK       = 8'hFF;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam logic [7:0]  LED_RESET      = 8'h00;
    // ==========================================================
    // mode encodings
    localparam logic [1:0]  PM_QUASI      = 2'h0;
    localparam logic [1:0]  PM_PUSH_PULL  = 2'h1;
    localparam logic [1:0]  PM_SLOW_OUT   = 2'h2;
    localparam logic [1:0]  PM_INPUT_WEAK = 2'h3;
    localparam logic [1:0]  P0_BUS_PORT   = 2'h0;
    localparam logic [1:0]  P0_RESERVED   = 2'h1;
    localparam logic [1:0]  P0_SLOW_OUT   = 2'h2;
    localparam logic [1:0]  P0_PUSH_PULL  = 2'h3;
    localparam logic [1:0]  LED_OFF       = 2'h0;
    localparam logic [1:0]  LED_2MA       = 2'h1;
    localparam logic [1:0]  LED_4MA       = 2'h2;
    localparam logic [1:0]  LED_10MA      = 2'h3;
    // ==========================================================
    // port 3 pins steered by the mode field, and led pin map
    localparam logic [7:0]  P3_MODE_PINS  = 8'h1B;
    localparam int          LED_NUM       = 4;
    localparam int          LED_PIN [4]   = '{2, 4, 6, 7};
endpackage : pm_pkg

// >>> rtl/cfg_byte_reg.sv
`timescale 1ns/10ps
module cfg_byte_reg
    import pm_pkg::*;
#(
    parameter logic [7:0] MASK  = 8'hFF,
    parameter logic [7:0] RST_V = 8'h00
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_q
);
    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    // ==========================================================
    // masked byte register, reserved bits held at zero
    always_comb begin
        nxt_q = q_ff;
        if (i_we) begin
            nxt_q = i_wdata & MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= RST_V & MASK;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign o_q = q_ff;
endmodule : cfg_byte_reg

// >>> rtl/pin_drive_decode.sv
`timescale 1ns/10ps
module pin_drive_decode
    import pm_pkg::*;
(
    input  wire logic [7:0]  i_mode_cfg,
    input  wire logic [7:0]  i_led_cfg,
    output logic      [15:0] o_p3_pin_mode,
    output logic      [1:0]  o_p2_mode,
    output logic      [1:0]  o_p0_mode,
    output logic             o_pullup_en,
    output logic      [7:0]  o_led_current
);
    logic [1:0] port3_mode_field;

    assign port3_mode_field = i_mode_cfg[P3_LSB +: 2];
    assign o_p2_mode        = i_mode_cfg[P2_LSB +: 2];
    assign o_p0_mode        = i_mode_cfg[P0_LSB +: 2];
    assign o_pullup_en      = ~i_mode_cfg[PULLUP_OFF_BIT];

    // ==========================================================
    // per-pin mode of port 3
    genvar gp;
    generate
        for (gp = 0; gp < 8; gp++) begin : g_pin
            assign o_p3_pin_mode[2*gp +: 2] = P3_MODE_PINS[gp] ?
                port3_mode_field : PM_QUASI;
        end
    endgenerate

    // ==========================================================
    // led current, gated by quasi mode of its pin
    genvar gl;
    generate
        for (gl = 0; gl < LED_NUM; gl++) begin : g_led
            localparam int PIN = LED_PIN[gl];
            assign o_led_current[2*gl +: 2] =
                (o_p3_pin_mode[2*PIN +: 2] == PM_QUASI) ?
                i_led_cfg[2*gl +: 2] : LED_OFF;
        end
    endgenerate
endmodule : pin_drive_decode

// >>> rtl/port_mode_led_config.sv
`timescale 1ns/10ps
module port_mode_led_config
    import pm_pkg::*;
#(
    parameter bit REDUCED = 1'b0
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic      [1:0]        o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic      [DATA_W-1:0] o_rdata,
    output logic      [1:0]        o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output logic      [15:0]       o_port3_pin_mode,
    output logic      [1:0]        o_port2_mode,
    output logic      [1:0]        o_port0_mode,
    output logic                   o_presence_pullup_en,
    output logic      [7:0]        o_led_current
);
    localparam logic [7:0] MODE_MASK = REDUCED ? MODE_MASK_RED
                                               : MODE_MASK_FULL;

    // ==========================================================
    // address decode
    function automatic logic is_mode(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2] == MODE_ADDR[ADDR_W-1:2];
    endfunction : is_mode

    function automatic logic is_led(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2] == LED_ADDR[ADDR_W-1:2];
    endfunction : is_led

    // ==========================================================
    // write channel state
    logic              aw_have_ff;
    logic              nxt_aw_have;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [ADDR_W-1:0] nxt_awaddr;
    logic              w_have_ff;
    logic              nxt_w_have;
    logic [7:0]        wbyte_ff;
    logic [7:0]        nxt_wbyte;
    logic              wlane_ff;
    logic              nxt_wlane;
    logic              awready_ff;
    logic              nxt_awready;
    logic              wready_ff;
    logic              nxt_wready;
    logic              bvalid_ff;
    logic              nxt_bvalid;
    logic [1:0]        bresp_ff;
    logic [1:0]        nxt_bresp;
    logic              wr_fire;
    logic              mode_we;
    logic              led_we;

    assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    assign mode_we = wr_fire && wlane_ff && is_mode(awaddr_ff);
    assign led_we  = wr_fire && wlane_ff && is_led(awaddr_ff);

    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_have  = w_have_ff;
        nxt_wbyte   = wbyte_ff;
        nxt_wlane   = wlane_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (i_awvalid && awready_ff) begin
            nxt_aw_have = 1'b1;
            nxt_awaddr  = i_awaddr;
        end
        if (i_wvalid && wready_ff) begin
            nxt_w_have = 1'b1;
            nxt_wbyte  = i_wdata[7:0];
            nxt_wlane  = i_wstrb[0];
        end
        if (bvalid_ff && i_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
            nxt_bvalid  = 1'b1;
            if (is_mode(awaddr_ff)) begin
                nxt_bresp = RESP_OKAY;
            end else if (is_led(awaddr_ff)) begin
                nxt_bresp = RESP_OKAY;
            end else begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        nxt_awready = !nxt_aw_have && !nxt_bvalid;
        nxt_wready  = !nxt_w_have && !nxt_bvalid;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_have_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_have_ff  <= 1'b0;
            wbyte_ff   <= 8'h00;
            wlane_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end else begin
            aw_have_ff <= nxt_aw_have;
            awaddr_ff  <= nxt_awaddr;
            w_have_ff  <= nxt_w_have;
            wbyte_ff   <= nxt_wbyte;
            wlane_ff   <= nxt_wlane;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
        end
    end

    // ==========================================================
    // configuration registers
    logic [7:0] mode_cfg;
    logic [7:0] led_cfg;

    cfg_byte_reg #(
        .MASK  (MODE_MASK),
        .RST_V (MODE_RESET)
    ) u_mode_reg (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_we    (mode_we),
        .i_wdata (wbyte_ff),
        .o_q     (mode_cfg)
    );

    cfg_byte_reg #(
        .MASK  (LED_MASK),
        .RST_V (LED_RESET)
    ) u_led_reg (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_we    (led_we),
        .i_wdata (wbyte_ff),
        .o_q     (led_cfg)
    );

    // ==========================================================
    // read channel
    logic              arready_ff;
    logic              nxt_arready;
    logic              rvalid_ff;
    logic              nxt_rvalid;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [1:0]        rresp_ff;
    logic [1:0]        nxt_rresp;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && i_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (i_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            if (is_mode(i_araddr)) begin
                nxt_rdata = {24'h000000, mode_cfg};
                nxt_rresp = RESP_OKAY;
            end else if (is_led(i_araddr)) begin
                nxt_rdata = {24'h000000, led_cfg};
                nxt_rresp = RESP_OKAY;
            end else begin
                nxt_rdata = '0;
                nxt_rresp = RESP_SLVERR;
            end
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign o_awready = awready_ff;
    assign o_wready  = wready_ff;
    assign o_bvalid  = bvalid_ff;
    assign o_bresp   = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid  = rvalid_ff;
    assign o_rdata   = rdata_ff;
    assign o_rresp   = rresp_ff;

    // ==========================================================
    // pad control decode and output registers
    logic [15:0] p3_pin_mode;
    logic [1:0]  p2_mode;
    logic [1:0]  p0_mode;
    logic        pullup_en;
    logic [7:0]  led_current;

    pin_drive_decode u_decode (
        .i_mode_cfg    (mode_cfg),
        .i_led_cfg     (led_cfg),
        .o_p3_pin_mode (p3_pin_mode),
        .o_p2_mode     (p2_mode),
        .o_p0_mode     (p0_mode),
        .o_pullup_en   (pullup_en),
        .o_led_current (led_current)
    );

    logic [15:0] p3_pin_mode_ff;
    logic [1:0]  p2_mode_ff;
    logic [1:0]  p0_mode_ff;
    logic        pullup_en_ff;
    logic [7:0]  led_current_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            p3_pin_mode_ff <= 16'h0000;
            p2_mode_ff     <= PM_QUASI;
            p0_mode_ff     <= P0_BUS_PORT;
            pullup_en_ff   <= 1'b1;
            led_current_ff <= 8'h00;
        end else begin
            p3_pin_mode_ff <= p3_pin_mode;
            p2_mode_ff     <= p2_mode;
            p0_mode_ff     <= p0_mode;
            pullup_en_ff   <= pullup_en;
            led_current_ff <= led_current;
        end
    end

    assign o_port3_pin_mode     = p3_pin_mode_ff;
    assign o_port2_mode         = p2_mode_ff;
    assign o_port0_mode         = p0_mode_ff;
    assign o_presence_pullup_en = pullup_en_ff;
    assign o_led_current        = led_current_ff;
endmodule : port_mode_led_config

// >>> dv/port_mode_led_config_props.sv
`timescale 1ns/10ps
module port_mode_led_config_props (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_awvalid,
    input  wire logic        o_awready,
    input  wire logic        i_wvalid,
    input  wire logic        o_wready,
    input  wire logic [1:0]  o_bresp,
    input  wire logic        o_bvalid,
    input  wire logic        i_bready,
    input  wire logic        i_arvalid,
    input  wire logic        o_arready,
    input  wire logic [31:0] o_rdata,
    input  wire logic [1:0]  o_rresp,
    input  wire logic        o_rvalid,
    input  wire logic        i_rready,
    input  wire logic [15:0] o_port3_pin_mode,
    input  wire logic [1:0]  o_port2_mode,
    input  wire logic [1:0]  o_port0_mode,
    input  wire logic        o_presence_pullup_en,
    input  wire logic [7:0]  o_led_current
);
    // ==========================================================
    // port and led controls, upper read data bits
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_P3_PINS: assert property (
        o_port3_pin_mode[15:10] == 6'h0 && o_port3_pin_mode[5:4] == 2'h0
        && o_port3_pin_mode[9:8] == o_port3_pin_mode[1:0]
        && o_port3_pin_mode[7:6] == o_port3_pin_mode[1:0]
        && o_port3_pin_mode[3:2] == o_port3_pin_mode[1:0])
        else $error("port 3 pin modes inconsistent");
    AST_LED_GATE: assert property (
        o_port3_pin_mode[9:8] != 2'h0 |-> o_led_current[3:2] == 2'h0)
        else $error("led drives on non quasi pin");
    AST_RESET_VAL: assert property (
        $past(i_rst) |-> o_led_current == 8'h0 && o_port2_mode == 2'h0
        && o_port0_mode == 2'h0 && o_port3_pin_mode == 16'h0
        && o_presence_pullup_en)
        else $error("pad controls not at reset value");
    AST_PAD_AFTER_WR: assert property (
        !$stable({o_port3_pin_mode, o_port2_mode, o_port0_mode,
                  o_presence_pullup_en, o_led_current}) |-> $past(o_bvalid))
        else $error("pad controls changed outside a write");
    AST_RDATA_RSV: assert property (
        o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    // ==========================================================
    // bus handshakes
    AST_WR_LAT: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready
        |=> !o_bvalid ##1 o_bvalid)
        else $error("write response timing wrong");
    AST_RD_LAT: assert property (
        i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read response timing wrong");
    AST_BV_HOLD: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    AST_RV_HOLD: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
        && $stable(o_rresp))
        else $error("read response dropped");
    AST_HS_BLOCK: assert property (
        o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while response pending");
endmodule : port_mode_led_config_props
bind port_mode_led_config port_mode_led_config_props u_props (.i_clk,
    .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .o_port3_pin_mode, .o_port2_mode, .o_port0_mode,
    .o_presence_pullup_en, .o_led_current);

// >>> dv/port_mode_led_config_tb.sv
`timescale 1ns/10ps
module port_mode_led_config_tb;
    import pm_pkg::*;
    logic        clk = 1'b0;
    logic        rst, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, o_rdata, seed;
    logic [3:0]  wstrb;
    logic [1:0]  o_bresp, o_rresp, o_port2_mode, o_port0_mode;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic        o_presence_pullup_en;
    logic [15:0] o_port3_pin_mode;
    logic [7:0]  o_led_current, m, l;
    logic [1:0]  bq [$];
    logic [33:0] rq [$];
    logic [33:0] re;
    logic [31:0] rdata_red, mk;
    logic [1:0]  p2_red, p0_red;
    logic [1:0]  p0c [3] = '{P0_BUS_PORT, P0_SLOW_OUT, P0_PUSH_PULL};
    int          errors = 0;
    int          checked = 0;
    always #20 clk = ~clk;
    port_mode_led_config DUT (.i_clk(clk), .i_rst(rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(rready), .o_port3_pin_mode(o_port3_pin_mode),
        .o_port2_mode(o_port2_mode), .o_port0_mode(o_port0_mode),
        .o_presence_pullup_en(o_presence_pullup_en),
        .o_led_current(o_led_current));
    port_mode_led_config #(.REDUCED(1'b1)) DUT_RED (.i_clk(clk),
        .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(),
        .o_bresp(), .o_bvalid(), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(), .o_rdata(rdata_red),
        .o_rresp(), .o_rvalid(), .i_rready(rready),
        .o_port3_pin_mode(), .o_port2_mode(p2_red),
        .o_port0_mode(p0_red), .o_presence_pullup_en(),
        .o_led_current());
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        bit aw;
        bit w;
        bq.push_back(r);
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && o_awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && o_wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        repeat (2) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!o_bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!o_arready);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!o_rvalid);
        rready <= 1'b0;
    endtask : rd
    task automatic pads(input logic [7:0] pm, input logic [7:0] pl);
        logic [7:0]  lc;
        logic [15:0] p3;
        lc = pl;
        p3 = {6'h0, {2{pm[7:6]}}, 2'h0, {2{pm[7:6]}}};
        if (pm[7:6] != PM_QUASI) lc[3:2] = LED_OFF;
        chk(32'(o_port3_pin_mode), 32'(p3));
        chk(32'({p2_red, p0_red}), 32'h0);
        chk(32'(o_port2_mode), 32'(pm[5:4]));
        chk(32'(o_presence_pullup_en), 32'(!pm[3]));
        chk(32'(o_port0_mode), 32'(pm[1:0]));
        chk(32'(o_led_current), 32'(lc));
    endtask : pads
    // ==========================================================
    // response watcher
    always @(posedge clk) begin
        if (o_bvalid && bready) begin
            if (bq.size() == 0) chk(32'h1, 32'h0);
            else chk(32'(o_bresp), 32'(bq.pop_front()));
        end
        if (o_rvalid && rready) begin
            if (rq.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                re = rq.pop_front();
                mk = (araddr[11:2] == MODE_ADDR[11:2]) ? 32'(MODE_MASK_RED)
                                                       : 32'hFFFFFFFF;
                chk(32'(o_rresp), 32'(re[33:32]));
                chk(o_rdata, re[31:0]);
                chk(rdata_red, re[31:0] & mk);
            end
        end
    end
    // ==========================================================
    // stimulus
    initial begin
        rst <= 1'b1;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        awaddr <= 12'h0;
        araddr <= 12'h0;
        wdata <= 32'h0;
        wstrb <= 4'h0;
        seed = 32'hE3577549;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pads(8'h00, 8'h00);
        rd(MODE_ADDR, 32'h0, RESP_OKAY);
        rd(LED_ADDR, 32'h0, RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            m = {i[1:0], i[3:2], seed[3], 1'b0, p0c[i % 3]};
            wr(MODE_ADDR, {seed[31:8], m}, {seed[6:4], 1'b1}, RESP_OKAY);
            seed = xs(seed);
            l = seed[7:0];
            wr(LED_ADDR, seed, 4'h1, RESP_OKAY);
            pads(m, l);
            rd(MODE_ADDR, {24'h0, m}, RESP_OKAY);
            rd(LED_ADDR, {24'h0, l}, RESP_OKAY);
        end
        wr(12'h100, 32'hFF, 4'hF, RESP_SLVERR);
        wr(LED_ADDR, ~{24'h0, l}, 4'hE, RESP_OKAY);
        pads(m, l);
        rd(12'h100, 32'h0, RESP_SLVERR);
        rd(LED_ADDR, {24'h0, l}, RESP_OKAY);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        pads(8'h00, 8'h00);
        rd(MODE_ADDR, 32'h0, RESP_OKAY);
        @(posedge clk);
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end
endmodule : port_mode_led_config_tb
